// >>> hw/twhcp_pkg.sv
package twhcp_pkg;
  // operational address: upper six bits identify this port
  localparam logic [5:0] OWN_ADDR     = 6'h18;
  localparam int         ADDR_ID_HI   = 7;
  localparam int         ADDR_ID_LO   = 2;
  // bits per serial byte, counted 0..7
  localparam logic [2:0] LAST_BIT     = 3'h7;
  // data operation modes carried in address bits 1..0
  typedef enum logic [1:0] {
    MODE_WR_ITEM   = 2'b00,
    MODE_RD_ITEM   = 2'b01,
    MODE_WR_CTRL   = 2'b10,
    MODE_RD_STATUS = 2'b11
  } twhcp_mode_t;
  // start-up sequence of the port after reset
  typedef enum logic [1:0] {
    INIT_WAIT_HI = 2'b00,
    INIT_WAIT_LO = 2'b01,
    INIT_RUN     = 2'b10
  } twhcp_init_t;
  // control codes
  localparam logic [7:0] CMD_SETTINGS  = 8'h00;
  localparam logic [7:0] CMD_DEC_HDR   = 8'h01;
  localparam logic [7:0] CMD_USED_HDR  = 8'h02;
  localparam logic [7:0] CMD_ERR_RPT   = 8'h03;
  localparam logic [7:0] CMD_RSVD_ITEM = 8'h04;
  localparam logic [7:0] CMD_ANC_DATA  = 8'h05;
  localparam logic [7:0] CMD_COEFF     = 8'h06;
  localparam logic [7:0] CMD_CONTINUE  = 8'h07;
  // status byte layout
  localparam int         ST_READY     = 0;
  localparam int         ST_SYNC      = 1;
  localparam int         ST_DSTATE_LO = 5;
  localparam logic [2:0] ST_UNDEF_VAL = 3'h0;
  // reset values
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // codes that open an item transfer
  function automatic logic is_item_cmd(input logic [7:0] code);
    return code <= CMD_COEFF;
  endfunction
endpackage

// >>> hw/twhcp_port.sv
`timescale 1ns/100ps
`default_nettype none
module twhcp_port #(
  parameter int IDX_W = 8  // item byte index width
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             ctl_serial_data_in,
  output wire logic             ctl_serial_data_out,
  output var  logic             ctl_serial_data_oe,
  input  wire logic             ctl_bit_clock,
  input  wire logic             addr_data_select,
  input  wire logic             core_ready,
  input  wire logic             input_sync_flag,
  input  wire logic [2:0]       decode_state,
  input  wire logic [7:0]       item_rd_data,
  output var  logic [7:0]       control_word,
  output var  logic             cmd_strobe,
  output var  logic             item_active,
  output var  logic [7:0]       item_cmd,
  output var  logic [IDX_W-1:0] byte_index,
  output var  logic [7:0]       item_wr_data,
  output var  logic             item_wr_strobe,
  output var  logic             item_rd_strobe,
  output var  logic             port_armed
);
  // refuse an index that cannot count
  if (IDX_W < 1) begin : g_chk
    $error("IDX_W must be at least 1");
  end

  logic                  clk_s1, clk_s2, clk_s3;   // bit clock sync and edge history
  logic                  sel_s1, sel_s2, sel_s3;   // select sync and edge history
  logic                  dat_s1, dat_s2;           // data sync
  twhcp_pkg::twhcp_init_t init_state;              // start-up progress
  logic [2:0]            bitcnt;                   // bits taken in current byte
  logic [7:0]            shreg_in;                 // incoming bits, lsb first
  logic [7:0]            shreg_out;                // outgoing bits, lsb first
  logic                  matched;                  // last address was ours
  twhcp_pkg::twhcp_mode_t mode;                    // held data operation mode
  logic                  ctl_seen;                 // a control byte arrived since reset
  logic                  reload_pend;              // load next outgoing byte
  logic                  saved_active;             // an item waits for continue
  logic [7:0]            saved_cmd;                // interrupted item code
  logic [IDX_W-1:0]      saved_index;              // interrupted item position
  logic                  run;                      // port armed
  logic                  clk_rise, clk_fall, sel_rise, sel_fall;
  logic                  byte_done, addr_done, data_done, ctl_done, item_done;
  logic [7:0]            byte_in;                  // completed byte
  logic [7:0]            status_byte;              // live status word

  // edges and byte completion, all on synchronised copies
  assign run       = (init_state == twhcp_pkg::INIT_RUN);
  assign clk_rise  = clk_s2 & ~clk_s3;
  assign clk_fall  = ~clk_s2 & clk_s3;
  assign sel_rise  = sel_s2 & ~sel_s3;
  assign sel_fall  = ~sel_s2 & sel_s3;
  assign byte_in   = {dat_s2, shreg_in[7:1]};
  assign byte_done = run & clk_rise & (bitcnt == twhcp_pkg::LAST_BIT);
  assign addr_done = byte_done & ~sel_s2;
  assign data_done = byte_done & sel_s2 & matched;
  assign ctl_done  = data_done & (mode == twhcp_pkg::MODE_WR_CTRL);
  assign item_done = data_done & item_active &
                     ((mode == twhcp_pkg::MODE_WR_ITEM) | (mode == twhcp_pkg::MODE_RD_ITEM));
  // ready only once a control byte was seen and the core can take a byte
  assign status_byte = {decode_state, twhcp_pkg::ST_UNDEF_VAL, input_sync_flag, ctl_seen & core_ready};
  assign ctl_serial_data_out = shreg_out[0];

  // pin synchronisers; first stages feed only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h7;
      {sel_s1, sel_s2, sel_s3} <= 3'h0;
      {dat_s1, dat_s2}         <= 2'h0;
    end else begin
      clk_s1 <= ctl_bit_clock;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      sel_s1 <= addr_data_select;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      dat_s1 <= ctl_serial_data_in;
      dat_s2 <= dat_s1;
    end
  end

  // start-up: select pulse with clock high before anything counts
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      init_state <= twhcp_pkg::INIT_WAIT_HI;
      port_armed <= 1'b0;
    end else begin
      port_armed <= run;
      case (init_state)
        twhcp_pkg::INIT_WAIT_HI: begin
          if (sel_rise & clk_s2) begin
            init_state <= twhcp_pkg::INIT_WAIT_LO;
          end
        end
        twhcp_pkg::INIT_WAIT_LO: begin
          // a clock pulse inside the select pulse spoils the sequence
          if (!clk_s2) begin
            init_state <= twhcp_pkg::INIT_WAIT_HI;
          end else if (sel_fall) begin
            init_state <= twhcp_pkg::INIT_RUN;
          end
        end
        twhcp_pkg::INIT_RUN: begin
          init_state <= twhcp_pkg::INIT_RUN;
        end
        default: begin
          init_state <= twhcp_pkg::INIT_WAIT_HI;
        end
      endcase
    end
  end

  // bit counter and input shifter; a select edge restarts the byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bitcnt   <= 3'h0;
      shreg_in <= twhcp_pkg::BYTE_RST;
    end else if (!run || sel_rise || sel_fall) begin
      bitcnt <= 3'h0;
    end else if (clk_rise) begin
      bitcnt   <= bitcnt + 3'h1;  // wraps to 0 after the eighth bit
      shreg_in <= byte_in;
    end
  end

  // address decode; every address is heard, whoever it is for
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      matched <= 1'b0;
      mode    <= twhcp_pkg::MODE_WR_ITEM;
    end else if (addr_done) begin
      matched <= (byte_in[twhcp_pkg::ADDR_ID_HI:twhcp_pkg::ADDR_ID_LO] == twhcp_pkg::OWN_ADDR);
      mode    <= twhcp_pkg::twhcp_mode_t'(byte_in[1:0]);
    end
  end

  // control word; no ready check needed, each one overrides
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_word <= twhcp_pkg::CTRL_RST;
      ctl_seen     <= 1'b0;
      cmd_strobe   <= 1'b0;
    end else begin
      cmd_strobe <= ctl_done;
      if (ctl_done) begin
        control_word <= byte_in;
        ctl_seen     <= 1'b1;
      end
    end
  end

  // item tracking; only one item can be parked for continue
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      item_active  <= 1'b0;
      item_cmd     <= twhcp_pkg::CTRL_RST;
      byte_index   <= '0;
      saved_active <= 1'b0;
      saved_cmd    <= twhcp_pkg::CTRL_RST;
      saved_index  <= '0;
    end else if (ctl_done) begin
      if (twhcp_pkg::is_item_cmd(byte_in)) begin
        // coefficient write parks the running item unless that item is itself a coefficient item
        if (byte_in == twhcp_pkg::CMD_COEFF && item_active && item_cmd != twhcp_pkg::CMD_COEFF) begin
          saved_active <= 1'b1;
          saved_cmd    <= item_cmd;
          saved_index  <= byte_index;
        end
        item_active <= 1'b1;
        item_cmd    <= byte_in;
        byte_index  <= '0;
      end else if (byte_in == twhcp_pkg::CMD_CONTINUE) begin
        if (saved_active) begin
          item_active  <= 1'b1;
          item_cmd     <= saved_cmd;
          byte_index   <= saved_index;
          saved_active <= 1'b0;
        end
      end else begin
        item_active <= 1'b0;
      end
    end else if (item_done) begin
      byte_index <= byte_index + IDX_W'(1);
    end
  end

  // item byte strobes toward the core
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      item_wr_data   <= twhcp_pkg::BYTE_RST;
      item_wr_strobe <= 1'b0;
      item_rd_strobe <= 1'b0;
    end else begin
      item_wr_strobe <= item_done & (mode == twhcp_pkg::MODE_WR_ITEM);
      item_rd_strobe <= item_done & (mode == twhcp_pkg::MODE_RD_ITEM);
      if (item_done && mode == twhcp_pkg::MODE_WR_ITEM) begin
        item_wr_data <= byte_in;
      end
    end
  end

  // outgoing byte: reloaded one cycle after a select rise or a data byte so the core can step
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reload_pend <= 1'b0;
      shreg_out   <= twhcp_pkg::BYTE_RST;
    end else begin
      reload_pend <= run & sel_s2 & matched & (sel_rise | byte_done);
      if (reload_pend) begin
        if (mode == twhcp_pkg::MODE_RD_STATUS) begin
          shreg_out <= status_byte;
        end else begin
          shreg_out <= item_active ? item_rd_data : twhcp_pkg::BYTE_RST;
        end
      end else if (clk_fall && bitcnt != 3'h0) begin
        shreg_out <= {1'b0, shreg_out[7:1]};
      end
    end
  end

  // pin drive only in a matched read with select high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl_serial_data_oe <= 1'b0;
    end else begin
      ctl_serial_data_oe <= run & sel_s2 & matched &
                            ((mode == twhcp_pkg::MODE_RD_ITEM) | (mode == twhcp_pkg::MODE_RD_STATUS));
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_no_drive_sel_low;
    !sel_s2 |=> !ctl_serial_data_oe;
  endproperty
  a_no_drive_sel_low: assert property (p_no_drive_sel_low) else $error("pin driven with select low");
  property p_ready_gated;
    !ctl_seen |-> !status_byte[twhcp_pkg::ST_READY];
  endproperty
  a_ready_gated: assert property (p_ready_gated) else $error("ready before first control byte");
  property p_match;
    addr_done && byte_in[7:2] == twhcp_pkg::OWN_ADDR |=> matched && mode == $past(byte_in[1:0]);
  endproperty
  a_match: assert property (p_match) else $error("own address not taken");
  property p_mismatch;
    addr_done && byte_in[7:2] != twhcp_pkg::OWN_ADDR |=> !matched ##1 !item_wr_strobe;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign address kept port engaged");
  property p_mode_hold;
    !addr_done |=> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved without address");
  property p_ctl_latest;
    ctl_done |=> control_word == $past(byte_in) && cmd_strobe;
  endproperty
  a_ctl_latest: assert property (p_ctl_latest) else $error("control byte not stored");
  property p_reserved;
    ctl_done && byte_in > twhcp_pkg::CMD_CONTINUE |=> !item_active ##1 !item_wr_strobe && !item_rd_strobe;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code opened item");
  property p_continue;
    ctl_done && byte_in == twhcp_pkg::CMD_CONTINUE && saved_active |=> item_cmd == $past(saved_cmd);
  endproperty
  a_continue: assert property (p_continue) else $error("continue lost parked item");
  property p_status_fresh;
    reload_pend && mode == twhcp_pkg::MODE_RD_STATUS |=> shreg_out == $past(status_byte);
  endproperty
  a_status_fresh: assert property (p_status_fresh) else $error("status not refreshed");
  property p_unarmed_idle;
    !run |-> !ctl_serial_data_oe && !matched;
  endproperty
  a_unarmed_idle: assert property (p_unarmed_idle) else $error("port active before arming");
endmodule // twhcp_port
`default_nettype wire

// >>> bench/twhcp_host.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial control bus
module twhcp_host (
  input  wire logic clock,
  input  wire logic data_wire,
  output var  logic bit_clk,
  output var  logic select,
  output var  logic host_d,
  output var  logic host_oe
);
  // idle: select low, clock high, pin released
  initial begin
    bit_clk = 1'b1;
    select  = 1'b0;
    host_d  = 1'b0;
    host_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // low first so the port sees a fresh rise, clock kept high
  task automatic arm();
    select <= 1'b0;
    wt(8);
    select <= 1'b1;
    wt(8);
    select <= 1'b0;
    wt(8);
  endtask
  // one byte lsb first; select low marks an address
  task automatic xfer(input logic sel, input logic drv, input logic [7:0] wb,
                      output logic [7:0] rb);
    if (select !== sel) begin
      select <= sel;
      wt(8);
    end
    host_oe <= drv;
    for (int i = 0; i < 8; i++) begin
      bit_clk <= 1'b0;
      host_d  <= wb[i];
      wt(4);
      bit_clk <= 1'b1;
      // sample mid-high: clear of the shift and of the reload
      wt(2);
      @(negedge clock);
      rb[i] = data_wire;
      wt(2);
    end
    wt(4);
    host_oe <= 1'b0;
    // let an edge pass so a following call never reassigns the enable in this step
    wt(1);
  endtask
endmodule // twhcp_host
`default_nettype wire

// >>> bench/tb_three_wire_host_control_port.sv
`timescale 1ns/100ps
`default_nettype none
module tb_three_wire_host_control_port;
  logic       clock, rstn, core_ready, input_sync_flag;
  logic       idle_tgl = 1'b0;
  logic [2:0] decode_state;
  logic [7:0] item_rd_data, control_word, item_cmd, byte_index, item_wr_data;
  logic       cmd_strobe, item_active, item_wr_strobe, item_rd_strobe, port_armed;
  logic       sd_out, sd_oe, bit_clk, select, host_d, host_oe;
  wire logic  data_wire;
  int         err_total = 0, cmp_count = 0, cyc = 0, n_cmd = 0, n_wr = 0, n_rd = 0, n_oe = 0;
  // address bytes of this port
  localparam logic [7:0] A_WI = {twhcp_pkg::OWN_ADDR, twhcp_pkg::MODE_WR_ITEM};
  localparam logic [7:0] A_RI = {twhcp_pkg::OWN_ADDR, twhcp_pkg::MODE_RD_ITEM};
  localparam logic [7:0] A_WC = {twhcp_pkg::OWN_ADDR, twhcp_pkg::MODE_WR_CTRL};
  localparam logic [7:0] A_RS = {twhcp_pkg::OWN_ADDR, twhcp_pkg::MODE_RD_STATUS};
  // no pull on the wire: undriven shows a changing pattern
  assign data_wire = sd_oe ? sd_out : (host_oe ? host_d : idle_tgl);
  twhcp_port #(.IDX_W(8)) uut (
    .clock(clock), .rstn(rstn), .ctl_serial_data_in(data_wire), .ctl_serial_data_out(sd_out),
    .ctl_serial_data_oe(sd_oe), .ctl_bit_clock(bit_clk), .addr_data_select(select),
    .core_ready(core_ready), .input_sync_flag(input_sync_flag), .decode_state(decode_state),
    .item_rd_data(item_rd_data), .control_word(control_word), .cmd_strobe(cmd_strobe),
    .item_active(item_active), .item_cmd(item_cmd), .byte_index(byte_index),
    .item_wr_data(item_wr_data), .item_wr_strobe(item_wr_strobe),
    .item_rd_strobe(item_rd_strobe), .port_armed(port_armed));
  twhcp_host host (.clock(clock), .data_wire(data_wire), .bit_clk(bit_clk), .select(select),
    .host_d(host_d), .host_oe(host_oe));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // strobe counters and hang guard
  always @(posedge clock) begin
    idle_tgl <= ~idle_tgl;
    cyc <= cyc + 1;
    if (cmd_strobe === 1'b1) n_cmd <= n_cmd + 1;
    if (item_wr_strobe === 1'b1) n_wr <= n_wr + 1;
    if (item_rd_strobe === 1'b1) n_rd <= n_rd + 1;
    if (sd_oe === 1'b1) n_oe <= n_oe + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  // bus helpers
  task automatic ad(input logic [7:0] a);
    logic [7:0] d;
    host.xfer(1'b0, 1'b1, a, d);
  endtask
  task automatic wr(input logic [7:0] b);
    logic [7:0] d;
    host.xfer(1'b1, 1'b1, b, d);
  endtask
  task automatic rd(output logic [7:0] b);
    host.xfer(1'b1, 1'b0, 8'h00, b);
  endtask
  task automatic poll(output logic [7:0] b);
    ad(A_RS);
    rd(b);
  endtask
  // traffic before arming is lost
  task automatic t_reset();
    chk1("oe", 1'b0, sd_oe);
    chk8("control_word", twhcp_pkg::CTRL_RST, control_word);
    chk1("port_armed", 1'b0, port_armed);
    ad(A_WC);
    wr(8'h05);
    chk8("unarmed_cmds", 8'h00, 8'(n_cmd));
    host.arm();
    chk1("port_armed", 1'b1, port_armed);
    $display("reset test done");
  endtask
  // first access: status, refreshed between reads
  task automatic t_status();
    logic [7:0] b0, b1;
    ad(A_RS);
    fork
      rd(b0);
      begin
        host.wt(30);
        decode_state <= 3'h3;
      end
    join
    rd(b1);
    chk1("oe_read", 1'b1, sd_oe);
    chk8("status", 8'ha2, b0);
    chk8("status_again", 8'h62, b1);
    $display("status test done");
  endtask
  // foreign addresses, each a single bit off
  task automatic t_foreign();
    logic [7:0] b;
    int c0, o0;
    ad(8'h22);
    chk1("oe_addr", 1'b0, sd_oe);
    c0 = n_cmd;
    o0 = n_oe;
    wr(8'h05);
    ad(8'h67);
    rd(b);
    chk8("foreign_cmds", 8'h00, 8'(n_cmd - c0));
    chk8("foreign_oe", 8'h00, 8'(n_oe - o0));
    chk8("control_word", 8'h00, control_word);
    $display("foreign test done");
  endtask
  // all item codes back to back under one address
  task automatic t_ctrl();
    logic [7:0] b;
    int c0;
    c0 = n_cmd;
    ad(A_WC);
    for (int c = 0; c < 7; c++) begin
      wr(8'(c));
      chk8("item_cmd", 8'(c), item_cmd);
      chk1("item_active", 1'b1, item_active);
    end
    wr(twhcp_pkg::CMD_DEC_HDR);
    chk8("cmd_count", 8'h08, 8'(n_cmd - c0));
    chk8("control_word", 8'h01, control_word);
    chk8("item_cmd", 8'h01, item_cmd);
    poll(b);
    chk8("status_ready", 8'h63, b);
    $display("control test done");
  endtask
  task automatic t_item_rd();
    logic [7:0] b;
    int r0;
    r0 = n_rd;
    item_rd_data <= 8'h3c;
    ad(A_RI);
    rd(b);
    chk8("item_byte0", 8'h3c, b);
    chk8("byte_index", 8'h01, byte_index);
    poll(b);
    chk1("ready_before_item", 1'b1, b[twhcp_pkg::ST_READY]);
    item_rd_data <= 8'hc5;
    ad(A_RI);
    rd(b);
    chk8("item_byte1", 8'hc5, b);
    chk8("rd_strobes", 8'h02, 8'(n_rd - r0));
    $display("item read test done");
  endtask
  // coefficient item interrupts, continue resumes
  task automatic t_cont();
    logic [7:0] b;
    int w0;
    w0 = n_wr;
    ad(A_WC);
    wr(twhcp_pkg::CMD_ANC_DATA);
    poll(b);
    chk1("ready_before_item", 1'b1, b[twhcp_pkg::ST_READY]);
    ad(A_RI);
    rd(b);
    chk8("item_byte_anc", 8'hc5, b);
    ad(A_WC);
    wr(twhcp_pkg::CMD_COEFF);
    chk8("item_cmd", twhcp_pkg::CMD_COEFF, item_cmd);
    ad(A_WI);
    wr(8'h9a);
    chk8("item_wr_data", 8'h9a, item_wr_data);
    // second byte moves the coefficient index away from the parked one
    wr(8'h9b);
    chk8("wr_strobes", 8'h02, 8'(n_wr - w0));
    ad(A_WC);
    wr(twhcp_pkg::CMD_CONTINUE);
    chk8("item_cmd", twhcp_pkg::CMD_ANC_DATA, item_cmd);
    chk8("byte_index", 8'h01, byte_index);
    $display("continue test done");
  endtask
  // reserved codes close the item, writes then vanish
  task automatic t_rsvd();
    logic [7:0] b;
    int w0;
    w0 = n_wr;
    ad(A_WC);
    wr(8'h08);
    chk1("item_active", 1'b0, item_active);
    wr(8'hff);
    chk1("item_active", 1'b0, item_active);
    ad(A_WI);
    wr(8'h55);
    chk8("wr_strobes", 8'h00, 8'(n_wr - w0));
    // core busy and out of sync: ready and sync both read low
    core_ready      <= 1'b0;
    input_sync_flag <= 1'b0;
    poll(b);
    chk8("status_busy", 8'h60, b);
    $display("reserved test done");
  endtask
  // second reset in mid-run: port must be armed again, ready cleared
  task automatic t_rerst();
    logic [7:0] b;
    rstn <= 1'b0;
    host.wt(2);
    chk1("oe_in_reset", 1'b0, sd_oe);
    chk1("port_armed", 1'b0, port_armed);
    chk8("control_word", twhcp_pkg::CTRL_RST, control_word);
    rstn <= 1'b1;
    host.wt(6);
    host.arm();
    core_ready <= 1'b1;
    poll(b);
    chk1("ready_after_reset", 1'b0, b[twhcp_pkg::ST_READY]);
    $display("second reset test done");
  endtask
  initial begin
    rstn = 1'b0;
    core_ready = 1'b1;
    input_sync_flag = 1'b1;
    decode_state = 3'h5;
    item_rd_data = 8'h00;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    host.wt(6);
    t_reset();
    t_status();
    t_foreign();
    t_ctrl();
    t_item_rd();
    t_cont();
    t_rsvd();
    t_rerst();
    complete_run();
  end
endmodule // tb_three_wire_host_control_port
`default_nettype wire
